// *** bench/rgb_group_bank_tb.sv ***
`timescale 1ns/100ps
module rgb_group_bank_tb;
  import rgb_pkg::*;
  logic        clk, resetn, valid, ready, en, int_n, sync;
  logic [47:0] gd;
  logic [5:0]  gf;
  logic [7:0]  addr, rdata, d;
  logic        newg, exp_upd;
  int          n_mismatch, check_count, cyc, low_cnt, i;

  rgb_group_bank rgb_group_bank_inst (.clk_i(clk), .resetn_i(resetn),
    .grp_valid_i(valid), .grp_ready_o(ready), .grp_byte2_i(gd[47:40]),
    .grp_byte3_i(gd[39:32]), .grp_byte4_i(gd[31:24]),
    .grp_byte5_i(gd[23:16]), .grp_byte6_i(gd[15:8]), .grp_byte7_i(gd[7:0]),
    .e_block_det_i(gf[5]), .third_block_type_i(gf[4]),
    .block_zero_error_i(gf[3]), .block_one_error_i(gf[2]),
    .block_two_error_i(gf[1]), .block_three_error_i(gf[0]),
    .block_sync_i(sync), .reg_addr_i(addr), .reg_rdata_o(rdata),
    .group_int_en_i(en), .int_n_o(int_n));

  rgb_host_model rgb_host_model_inst (.clk_i(clk), .reg_rdata_i(rdata),
    .reg_addr_o(addr), .new_grp_o(newg));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task results;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Holds the group until the edge that sees ready high
  task push(input logic [47:0] dd, input logic [5:0] ff);
    @(negedge clk);
    valid = 1'b1;
    gd    = dd;
    gf    = ff;
    while (ready !== 1'b1)
      @(negedge clk);
    @(negedge clk);
    valid = 1'b0;
  endtask

  task check_grp(input logic [47:0] dd, input logic [5:0] ff);
    for (int k = 0; k < 6; k++)
    begin
      rgb_host_model_inst.rd(8'h0d + k[7:0], d);
      chk(d, dd[47-8*k -: 8]);
    end
    rgb_host_model_inst.rd(OFF_GROUP_RECEIVE_STATUS, d);
    chk(d, {exp_upd, ff[5:4], sync, ff[3:0]});
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (!int_n)
      low_cnt++;
    if (cyc == 98000)
    begin
      n_mismatch++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    {valid, en, resetn} = 3'b000;
    sync = 1'b1;
    gd   = 48'h0;
    gf   = 6'h0;
    exp_upd = 1'b0;
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    check_grp(48'h0, 6'h0);
    rgb_host_model_inst.rd(8'h20, d);
    chk(d, UNMAPPED_VAL);
    // Disabled interrupt: toggles, no pulse
    push(48'ha1b2c3d4e5f6, 6'b011000);
    exp_upd = ~exp_upd;
    repeat (4) @(negedge clk);
    check_grp(48'ha1b2c3d4e5f6, 6'b011000);
    chk(newg, 1'b1);
    sync = 1'b0;
    push(48'h0f1e2d3c4b5a, 6'b100001);
    exp_upd = ~exp_upd;
    repeat (4) @(negedge clk);
    check_grp(48'h0f1e2d3c4b5a, 6'b100001);
    chk(low_cnt, 0);
    // Enabled pulse, groups queue behind it
    en = 1'b1;
    push(48'h112233445566, 6'b000110);
    exp_upd = ~exp_upd;
    i = 0;
    while (int_n !== 1'b0 && i < 20)
    begin
      @(negedge clk);
      i++;
    end
    chk(int_n, 1'b0);
    rgb_host_model_inst.rd(OFF_GROUP_RECEIVE_STATUS, d);
    chk(d, {exp_upd, 2'b00, sync, 4'b0110});
    en = 1'b0;
    for (i = 0; i < 16; i++)
      push({6{i[7:0]}}, i[5:0]);
    @(negedge clk);
    valid = 1'b1;
    @(negedge clk);
    chk(ready, 1'b0);
    valid = 1'b0;
    rgb_host_model_inst.rd(OFF_GROUP_RECEIVE_STATUS, d);
    chk(newg, 1'b0);
    i = 0;
    while (int_n !== 1'b1 && i < 95000)
    begin
      @(negedge clk);
      i++;
    end
    chk(low_cnt, INT_PULSE_CYC);
    repeat (100) @(negedge clk);
    chk(ready, 1'b1);
    check_grp({6{8'h0f}}, 6'h0f);
    chk(low_cnt, INT_PULSE_CYC);
    results();
  end
endmodule

// *** bench/rgb_host_model.sv ***
`timescale 1ns/100ps
module rgb_host_model
(
  input  wire logic       clk_i,
  input  wire logic [7:0] reg_rdata_i,
  output logic      [7:0] reg_addr_o,
  output logic            new_grp_o
);
  logic last_upd;

  initial
  begin
    reg_addr_o = 8'h00;
    new_grp_o  = 1'b0;
    last_upd   = 1'b0;
  end

  // Address held a full cycle; data taken at the next falling edge
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    @(negedge clk_i);
    d = reg_rdata_i;
    if (a == 8'h13)
    begin
      new_grp_o = (d[7] !== last_upd);
      last_upd  = d[7];
    end
  endtask
endmodule

// *** rtl/rgb_fifo.sv ***
`timescale 1ns/100ps
module rgb_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)
(
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count_r != (AW+1)'(DEPTH));
  assign out_valid_o = (count_r != '0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem_r[rd_ptr_r];

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push && !pop)
      begin
        count_r <= count_r + 1'b1;
      end
      else if (pop && !push)
      begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule

// *** rtl/rgb_group_bank.sv ***
// Summary of operation
// - Bit 7 of the status register toggles each time a new group lands.
// - With the enable set, the interrupt goes low 4.5 ms as the bit toggles.
// - Status bit 5 gives the third block type, 0 for C0 and 1 for C1.
// - Status bits 3 to 0 are the error flags of blocks 0, 1, 2 and 3.
// - An error flag reads 1 for a block with an error and 0 otherwise.
`timescale 1ns/100ps
module rgb_group_bank
  import rgb_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  // Decoder side: one completed group per accepted strobe
  input  wire logic       grp_valid_i,
  output logic            grp_ready_o,
  input  wire logic [7:0] grp_byte2_i,
  input  wire logic [7:0] grp_byte3_i,
  input  wire logic [7:0] grp_byte4_i,
  input  wire logic [7:0] grp_byte5_i,
  input  wire logic [7:0] grp_byte6_i,
  input  wire logic [7:0] grp_byte7_i,
  input  wire logic       third_block_type_i,
  input  wire logic       e_block_det_i,
  input  wire logic       block_zero_error_i,
  input  wire logic       block_one_error_i,
  input  wire logic       block_two_error_i,
  input  wire logic       block_three_error_i,
  input  wire logic       block_sync_i,
  // Register read port
  input  wire logic [7:0] reg_addr_i,
  output logic [7:0]      reg_rdata_o,
  input  wire logic       group_int_en_i,
  output logic            int_n_o
);

  ////////////////////////////////////////////////////////////////////////////
  logic [GRP_W-1:0]     in_word;
  logic [GRP_W-1:0]     head_word;
  logic                 head_valid;
  logic                 load;
  logic [7:0]           data_r [6];
  logic [7:0]           status_r;
  logic [7:0]           rdata_nxt;
  rgb_int_state_t       int_state_r;
  logic [INT_CNT_W-1:0] int_cnt_r;

  assign in_word = {grp_byte2_i, grp_byte3_i, grp_byte4_i, grp_byte5_i,
                    grp_byte6_i, grp_byte7_i, e_block_det_i,
                    third_block_type_i, block_zero_error_i,
                    block_one_error_i, block_two_error_i,
                    block_three_error_i};

  // Buffer lets bursts of groups queue while the pulse logic drains them
  rgb_fifo #(
    .WIDTH (GRP_W),
    .DEPTH (FIFO_DEPTH)
  ) rgb_fifo_inst (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (grp_valid_i),
    .in_ready_o  (grp_ready_o),
    .in_data_i   (in_word),
    .out_valid_o (head_valid),
    .out_ready_i (load),
    .out_data_o  (head_word)
  );

  // One group per pulse slot so every toggle gets its own interrupt
  assign load = head_valid && (int_state_r == RGB_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      for (int i = 0; i < 6; i++)
      begin
        data_r[i] <= DATA_RESET;
      end
    end
    else if (load)
    begin
      for (int i = 0; i < 6; i++)
      begin
        data_r[i] <= head_word[GRP_W-1-8*i -: 8];
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      status_r <= STATUS_RESET;
    end
    else
    begin
      status_r[STS_SYNC_BIT] <= block_sync_i;
      if (load)
      begin
        status_r[STS_UPDATE_BIT] <= ~status_r[STS_UPDATE_BIT];
        status_r[STS_E_DET_BIT]  <= head_word[5];
        status_r[STS_TYPE_BIT]   <= head_word[4];
        status_r[STS_ERR_HI:STS_ERR_LO] <= head_word[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      int_state_r <= RGB_IDLE;
      int_cnt_r   <= '0;
    end
    else
    begin
      case (int_state_r)
        RGB_IDLE:
        begin
          if (load && group_int_en_i)
          begin
            int_state_r <= RGB_PULSE;
            int_cnt_r   <= INT_CNT_W'(INT_PULSE_CYC - 1);
          end
        end
        RGB_PULSE:
        begin
          if (int_cnt_r == '0)
          begin
            int_state_r <= RGB_IDLE;
          end
          else
          begin
            int_cnt_r <= int_cnt_r - 1'b1;
          end
        end
        default:
        begin
          int_state_r <= RGB_IDLE;
        end
      endcase
    end
  end

  assign int_n_o = (int_state_r != RGB_PULSE);

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; writes do not exist on this port
  always_comb
  begin
    case (reg_addr_i)
      OFF_GROUP_DATA_BYTE2:     rdata_nxt = data_r[0];
      OFF_GROUP_DATA_BYTE3:     rdata_nxt = data_r[1];
      OFF_GROUP_DATA_BYTE4:     rdata_nxt = data_r[2];
      OFF_GROUP_DATA_BYTE5:     rdata_nxt = data_r[3];
      OFF_GROUP_DATA_BYTE6:     rdata_nxt = data_r[4];
      OFF_GROUP_DATA_BYTE7:     rdata_nxt = data_r[5];
      OFF_GROUP_RECEIVE_STATUS: rdata_nxt = status_r;
      default:                  rdata_nxt = UNMAPPED_VAL;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      reg_rdata_o <= UNMAPPED_VAL;
    end
    else
    begin
      reg_rdata_o <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_toggle_on_load;
    @(posedge clk_i) disable iff (!resetn_i)
    load |=> (status_r[STS_UPDATE_BIT] != $past(status_r[STS_UPDATE_BIT]));
  endproperty
  a_toggle_on_load: assert property (p_toggle_on_load)
    else $error("update bit did not toggle on group load");

  property p_no_toggle_idle;
    @(posedge clk_i) disable iff (!resetn_i)
    !load |=> $stable(status_r[STS_UPDATE_BIT]);
  endproperty
  a_no_toggle_idle: assert property (p_no_toggle_idle)
    else $error("update bit changed without a group");

  property p_int_with_toggle;
    @(posedge clk_i) disable iff (!resetn_i)
    (load && group_int_en_i) |=> !int_n_o && $changed(status_r[7]);
  endproperty
  a_int_with_toggle: assert property (p_int_with_toggle)
    else $error("interrupt not asserted with toggle");

  property p_int_only_when_enabled;
    @(posedge clk_i) disable iff (!resetn_i)
    (int_state_r == RGB_IDLE && !(load && group_int_en_i)) |=> int_n_o;
  endproperty
  a_int_only_when_enabled: assert property (p_int_only_when_enabled)
    else $error("interrupt pulse without enabled group");

  property p_pulse_len;
    @(posedge clk_i) disable iff (!resetn_i)
    (int_state_r == RGB_PULSE && int_cnt_r == '0) |=> int_n_o;
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("interrupt pulse too long");

  property p_type_bit;
    @(posedge clk_i) disable iff (!resetn_i)
    load |=> status_r[STS_TYPE_BIT] == $past(head_word[4]);
  endproperty
  a_type_bit: assert property (p_type_bit)
    else $error("third block type not stored");

  property p_err_bits;
    @(posedge clk_i) disable iff (!resetn_i)
    load |=> status_r[3:0] == $past(head_word[3:0]);
  endproperty
  a_err_bits: assert property (p_err_bits)
    else $error("block error flags not stored");

  property p_consistent;
    @(posedge clk_i) disable iff (!resetn_i)
    load |=> data_r[5] == $past(head_word[13:6])
             && status_r[0] == $past(head_word[0]);
  endproperty
  a_consistent: assert property (p_consistent)
    else $error("data and status not updated together");

  property p_read_status;
    @(posedge clk_i) disable iff (!resetn_i)
    (reg_addr_i == OFF_GROUP_RECEIVE_STATUS) |=> reg_rdata_o == $past(status_r);
  endproperty
  a_read_status: assert property (p_read_status)
    else $error("status read returned wrong value");

endmodule

// *** rtl/rgb_pkg.sv ***
package rgb_pkg;

  // Register offsets on the device's register address space
  localparam logic [7:0] OFF_GROUP_DATA_BYTE2     = 8'h0d;
  localparam logic [7:0] OFF_GROUP_DATA_BYTE3     = 8'h0e;
  localparam logic [7:0] OFF_GROUP_DATA_BYTE4     = 8'h0f;
  localparam logic [7:0] OFF_GROUP_DATA_BYTE5     = 8'h10;
  localparam logic [7:0] OFF_GROUP_DATA_BYTE6     = 8'h11;
  localparam logic [7:0] OFF_GROUP_DATA_BYTE7     = 8'h12;
  localparam logic [7:0] OFF_GROUP_RECEIVE_STATUS = 8'h13;

  // Status field positions
  localparam int STS_UPDATE_BIT = 7;
  localparam int STS_E_DET_BIT  = 6;
  localparam int STS_TYPE_BIT   = 5;
  localparam int STS_SYNC_BIT   = 4;
  localparam int STS_ERR_HI     = 3;
  localparam int STS_ERR_LO     = 0;

  localparam logic [7:0] DATA_RESET   = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_VAL = 8'h00;

  // Interrupt low pulse length
  localparam int CLK_HZ           = 20000000;
  localparam int INT_PULSE_US_X10 = 45000;
  localparam int INT_PULSE_CYC    = (CLK_HZ / 10000) * INT_PULSE_US_X10 / 1000;
  localparam int INT_CNT_W        = 17;

  // Group record: 6 data bytes, type, e-det, 4 errors
  localparam int GRP_W      = 54;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [1:0]
  {
    RGB_IDLE  = 2'b01,
    RGB_PULSE = 2'b10
  } rgb_int_state_t;

endpackage
